/* src/pss_pkg.sv */
package pss_pkg;

  // ****************************************************************
  // clock and tick timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 10000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 3;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TARGET = 8'h04;
  localparam logic [7:0] OFF_GAIN = 8'h08;
  localparam logic [7:0] OFF_INTDER = 8'h0C;
  localparam logic [7:0] OFF_LIMIT = 8'h10;
  localparam logic [7:0] OFF_BIAS = 8'h14;
  localparam logic [7:0] OFF_FILTER = 8'h18;
  localparam logic [7:0] OFF_LOSS = 8'h1C;
  localparam logic [7:0] OFF_SLEEP = 8'h20;
  localparam logic [7:0] OFF_WAKE = 8'h24;
  localparam logic [7:0] OFF_DISPLAY = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;
  localparam logic [7:0] OFF_OUTPUT = 8'h30;
  localparam int NUM_CFG = 11;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_INVERT = 1;
  localparam int CTRL_DER_FB = 2;
  localparam int CTRL_ADD_TGT = 3;
  localparam int CTRL_REV_ALLOW = 4;
  localparam int CTRL_LOSS_LSB = 8;
  localparam int CTRL_SLEEP_LSB = 12;
  localparam int CTRL_TGT_LSB = 16;
  localparam int CTRL_FB_LSB = 20;
  localparam int STAT_ENABLED = 0;
  localparam int STAT_LOSS = 1;
  localparam int STAT_FAULT = 2;
  localparam int STAT_SLEEP = 3;
  localparam int STAT_REVERSE = 4;
  localparam int STAT_CONFLICT = 5;
  localparam int DI_BYPASS = 0;
  localparam int DI_SLEEP = 1;

  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [31:0] CTRL_RST = 32'h0021_0000;
  localparam logic [31:0] GAIN_RST = 32'h0100_0100;
  localparam logic [31:0] LIMIT_RST = 32'h1000_1000;
  localparam logic [31:0] BIAS_RST = 32'h0100_0000;
  localparam logic [15:0] FULL_SCALE = 16'h1000;
  localparam logic [2:0] SRC_AIN_ONE = 3'h1;
  localparam logic [2:0] SRC_AIN_TWO = 3'h2;
  localparam logic [2:0] SRC_SETTING = 3'h4;
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_ONE = 2'h1;
  localparam logic [1:0] SEL_TWO = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PSS_RUN = 2'h0,
    PSS_SLEEP = 2'h1,
    PSS_FAULT = 2'h3
  } pss_mode_type;

endpackage : pss_pkg

/* src/pss_supervisor.sv */
`timescale 1ns/1ns
module pss_supervisor #(
  parameter int TICK_CYCLES = pss_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog inputs, taken raw; whichever one is feedback is scaled by the low half of the gain setting
  input wire logic [15:0] analog_input_one,
  input wire logic [15:0] analog_input_two,
  // drive side
  input wire logic [15:0] base_freq_ref,
  input wire logic [15:0] output_freq,
  input wire logic [1:0] multi_function_digital_input,
  output logic [15:0] freq_ref_out,
  output logic reverse_out,
  output logic run_enable_out,
  output logic fault_relay_out,
  output logic feedback_loss_message,
  output logic source_conflict_alarm,
  output logic [15:0] display_value
);
  import pss_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [NUM_CFG-1:0][31:0] cfg;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0][SYNC_STAGES-1:0] di_sync;
    logic [1:0] di_ok;
    logic [16:0] tick_cnt;
    logic signed [17:0] tgt_r;
    logic signed [17:0] fb_prev;
    logic signed [17:0] err_prev;
    logic signed [17:0] integ;
    logic signed [17:0] filt;
    logic [15:0] loss_cnt;
    logic [15:0] sleep_cnt;
    logic [15:0] wake_cnt;
    pss_mode_type mode;
    logic [15:0] freq;
    logic reverse;
    logic run_en;
    logic relay;
    logic loss_msg;
    logic conflict;
    logic [15:0] disp;
  } pss_state_type;

  pss_state_type st_ff;
  pss_state_type nxt_st;

  function automatic logic signed [17:0] pss_clamp(input logic signed [39:0] v,
                                                   input logic [15:0] lim);
    logic signed [39:0] hi;
    logic signed [39:0] lo;
    hi = signed'({24'h000000, lim});
    lo = -hi;
    if (v > hi) begin
      pss_clamp = hi[17:0];
    end else if (v < lo) begin
      pss_clamp = lo[17:0];
    end else begin
      pss_clamp = v[17:0];
    end
  endfunction : pss_clamp

  // ****************************************************************
  // configuration fields
  // ****************************************************************
  logic [31:0] ctrl;
  logic loop_en;
  logic [1:0] loss_sel;
  logic [1:0] sleep_sel;
  logic [2:0] tgt_src;
  logic [2:0] fb_src;
  logic tick;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;

  assign ctrl = st_ff.cfg[OFF_CTRL[5:2]];
  assign loop_en = ctrl[CTRL_ENABLE];
  assign loss_sel = ctrl[CTRL_LOSS_LSB +: 2];
  assign sleep_sel = ctrl[CTRL_SLEEP_LSB +: 2];
  assign tgt_src = ctrl[CTRL_TGT_LSB +: 3];
  assign fb_src = ctrl[CTRL_FB_LSB +: 3];
  assign tick = (st_ff.tick_cnt == 17'(TICK_CYCLES - 1));
  assign wr_idx = st_ff.awaddr[5:2];
  assign rd_idx = s_axi_araddr[5:2];

  // ****************************************************************
  // loop arithmetic
  // ****************************************************************
  logic signed [17:0] tgt_sel;
  logic signed [17:0] fb_raw;
  logic signed [17:0] fb_s;
  logic signed [17:0] ramp_step;
  logic signed [17:0] tgt_next;
  logic signed [17:0] err;
  logic signed [17:0] der_in;
  logic signed [17:0] integ_next;
  logic signed [17:0] lim_out;
  logic signed [17:0] filt_next;
  logic signed [39:0] mul_p;
  logic signed [39:0] mul_i;
  logic signed [39:0] mul_d;
  logic signed [39:0] sum;
  logic signed [39:0] comp;
  logic signed [39:0] freq_sum;
  logic signed [39:0] disp_sum;
  logic loss_now;
  logic sleep_allowed;
  logic sleep_expire;
  logic wake_expire;

  always_comb begin
    case (tgt_src)
      SRC_AIN_ONE: tgt_sel = signed'({2'b00, analog_input_one});
      SRC_AIN_TWO: tgt_sel = signed'({2'b00, analog_input_two});
      SRC_SETTING: tgt_sel = signed'({2'b00, st_ff.cfg[OFF_TARGET[5:2]][15:0]});
      default: tgt_sel = 18'sh00000;
    endcase
    case (fb_src)
      SRC_AIN_ONE: fb_raw = signed'({2'b00, analog_input_one});
      SRC_AIN_TWO: fb_raw = signed'({2'b00, analog_input_two});
      default: fb_raw = 18'sh00000;
    endcase
    mul_p = 40'(fb_raw) * signed'({24'h000000, st_ff.cfg[OFF_GAIN[5:2]][15:0]});
    fb_s = pss_clamp(mul_p >>> 8, FULL_SCALE);
    ramp_step = signed'({2'b00, st_ff.cfg[OFF_FILTER[5:2]][31:16]});
    // a zero step means no ramp time programmed
    if (st_ff.di_ok[DI_BYPASS] || ramp_step == 18'sh00000) begin
      tgt_next = tgt_sel;
    end else if (tgt_sel > st_ff.tgt_r + ramp_step) begin
      tgt_next = st_ff.tgt_r + ramp_step;
    end else if (tgt_sel < st_ff.tgt_r - ramp_step) begin
      tgt_next = st_ff.tgt_r - ramp_step;
    end else begin
      tgt_next = tgt_sel;
    end
    err = ctrl[CTRL_INVERT] ? (fb_s - tgt_next) : (tgt_next - fb_s);
    mul_p = 40'(err) * signed'({24'h000000, st_ff.cfg[OFF_GAIN[5:2]][31:16]});
    mul_i = 40'(err) * signed'({24'h000000, st_ff.cfg[OFF_INTDER[5:2]][15:0]});
    integ_next = pss_clamp(40'(st_ff.integ) + (mul_i >>> 8),
                           st_ff.cfg[OFF_LIMIT[5:2]][15:0]);
    der_in = ctrl[CTRL_DER_FB] ? (st_ff.fb_prev - fb_s) : (err - st_ff.err_prev);
    mul_d = 40'(der_in) * signed'({24'h000000, st_ff.cfg[OFF_INTDER[5:2]][31:16]});
    sum = (mul_p >>> 8) + 40'(integ_next) + (mul_d >>> 8);
    if (ctrl[CTRL_ADD_TGT]) begin
      sum = sum + 40'(tgt_next);
    end
    lim_out = pss_clamp(sum, st_ff.cfg[OFF_LIMIT[5:2]][31:16]);
    filt_next = st_ff.filt
              + ((lim_out - st_ff.filt) >>> st_ff.cfg[OFF_FILTER[5:2]][3:0]);
    comp = 40'(filt_next) + 40'(signed'(st_ff.cfg[OFF_BIAS[5:2]][15:0]));
    comp = comp * signed'({24'h000000, st_ff.cfg[OFF_BIAS[5:2]][31:16]});
    freq_sum = signed'({24'h000000, base_freq_ref}) + (comp >>> 8);
    disp_sum = 40'(signed'(st_ff.cfg[OFF_DISPLAY[5:2]][15:0]))
             + ((40'(fb_s) * signed'({24'h000000, st_ff.cfg[OFF_DISPLAY[5:2]][31:16]}))
               >>> 12);
    loss_now = (loss_sel != SEL_OFF) && (fb_s < signed'({2'b00,
                st_ff.cfg[OFF_LOSS[5:2]][15:0]}));
    sleep_allowed = (sleep_sel == SEL_ONE)
                 || (sleep_sel == SEL_TWO && st_ff.di_ok[DI_SLEEP]);
    sleep_expire = sleep_allowed && (output_freq < st_ff.cfg[OFF_SLEEP[5:2]][15:0])
                && (st_ff.sleep_cnt >= st_ff.cfg[OFF_SLEEP[5:2]][31:16]);
    wake_expire = (st_ff.freq > st_ff.cfg[OFF_WAKE[5:2]][15:0])
               && (st_ff.wake_cnt >= st_ff.cfg[OFF_WAKE[5:2]][31:16]);
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    // three-stage pin synchroniser, value taken once the last two agree
    for (int i = 0; i < 2; i++) begin
      nxt_st.di_sync[i] = {st_ff.di_sync[i][1:0], multi_function_digital_input[i]};
      if (st_ff.di_sync[i][1] == st_ff.di_sync[i][2]) begin
        nxt_st.di_ok[i] = st_ff.di_sync[i][2];
      end
    end
    // axi write: address and data taken in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      // upper address bits must be clear, or a high offset would alias a setting
      if (int'(wr_idx) < NUM_CFG && st_ff.awaddr[1:0] == 2'h0
          && st_ff.awaddr[7:6] == 2'h0) begin
        for (int b = 0; b < 4; b++) begin
          if (st_ff.wstrb[b]) begin
            nxt_st.cfg[wr_idx][b*8 +: 8] = st_ff.wdata[b*8 +: 8];
          end
        end
      end else if (st_ff.awaddr != OFF_STATUS) begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;
    // axi read
    nxt_st.arready = 1'b0;
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_ff.arready && !st_ff.rvalid) begin
      nxt_st.arready = 1'b1;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = 32'h00000000;
      if (int'(rd_idx) < NUM_CFG && s_axi_araddr[1:0] == 2'h0
          && s_axi_araddr[7:6] == 2'h0) begin
        nxt_st.rdata = st_ff.cfg[rd_idx];
      end else if (s_axi_araddr == OFF_STATUS) begin
        nxt_st.rdata[STAT_ENABLED] = loop_en;
        nxt_st.rdata[STAT_LOSS] = st_ff.loss_msg;
        nxt_st.rdata[STAT_FAULT] = st_ff.mode == PSS_FAULT;
        nxt_st.rdata[STAT_SLEEP] = st_ff.mode == PSS_SLEEP;
        nxt_st.rdata[STAT_REVERSE] = st_ff.reverse;
        nxt_st.rdata[STAT_CONFLICT] = st_ff.conflict;
      end else if (s_axi_araddr == OFF_OUTPUT) begin
        nxt_st.rdata = {st_ff.disp, st_ff.freq};
      end else begin
        nxt_st.rresp = RESP_SLVERR;
      end
    end
    nxt_st.conflict = (tgt_src == fb_src);
    nxt_st.tick_cnt = tick ? 17'h00000 : st_ff.tick_cnt + 17'h00001;
    // the loop keeps running in every mode so wake can be judged
    if (tick) begin
      nxt_st.tgt_r = tgt_next;
      nxt_st.disp = disp_sum[15:0];
      if (loop_en && !st_ff.conflict) begin
        nxt_st.integ = integ_next;
        nxt_st.filt = filt_next;
        nxt_st.fb_prev = fb_s;
        nxt_st.err_prev = err;
        nxt_st.reverse = 1'b0;
        if (freq_sum < 40'sh0) begin
          nxt_st.reverse = ctrl[CTRL_REV_ALLOW];
          nxt_st.freq = ctrl[CTRL_REV_ALLOW] ? 16'(pss_clamp(-freq_sum, FULL_SCALE))
                                            : 16'h0000;
        end else begin
          nxt_st.freq = 16'(pss_clamp(freq_sum, FULL_SCALE));
        end
      end else begin
        nxt_st.integ = 18'sh00000;
        nxt_st.filt = 18'sh00000;
        nxt_st.reverse = 1'b0;
        nxt_st.freq = base_freq_ref;
      end
      // timers restart on the first tick their condition is gone; a loss timer at FFFF keeps its value
      nxt_st.loss_cnt = loss_now ? st_ff.loss_cnt + 16'h0001 : 16'h0000;
      if (st_ff.loss_cnt == 16'hFFFF) begin
        nxt_st.loss_cnt = st_ff.loss_cnt;
      end
      if (st_ff.mode == PSS_RUN && sleep_allowed
          && output_freq < st_ff.cfg[OFF_SLEEP[5:2]][15:0]) begin
        nxt_st.sleep_cnt = st_ff.sleep_cnt + 16'h0001;
      end else begin
        nxt_st.sleep_cnt = 16'h0000;
      end
      if (st_ff.mode == PSS_SLEEP && st_ff.freq > st_ff.cfg[OFF_WAKE[5:2]][15:0]) begin
        nxt_st.wake_cnt = st_ff.wake_cnt + 16'h0001;
      end else begin
        nxt_st.wake_cnt = 16'h0000;
      end
      nxt_st.loss_msg = loss_now
                     && st_ff.loss_cnt >= st_ff.cfg[OFF_LOSS[5:2]][31:16];
    end
    // a software clear of the fault loses to a loss event in the same cycle
    if (st_ff.aw_got && st_ff.w_got && st_ff.awaddr == OFF_STATUS
        && st_ff.wstrb[0] && st_ff.wdata[STAT_FAULT] && st_ff.mode == PSS_FAULT) begin
      nxt_st.mode = PSS_RUN;
    end
    case (st_ff.mode)
      PSS_RUN: begin
        if (tick && sleep_expire) begin
          nxt_st.mode = PSS_SLEEP;
        end
      end
      PSS_SLEEP: begin
        if (tick && (wake_expire || !sleep_allowed)) begin
          nxt_st.mode = PSS_RUN;
        end
      end
      PSS_FAULT: begin
      end
      default: nxt_st.mode = PSS_RUN;
    endcase
    if (nxt_st.loss_msg && loss_sel == SEL_TWO) begin
      nxt_st.mode = PSS_FAULT;
    end
    nxt_st.run_en = (nxt_st.mode == PSS_RUN);
    nxt_st.relay = (nxt_st.mode == PSS_FAULT);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.cfg[OFF_CTRL[5:2]] <= CTRL_RST;
      st_ff.cfg[OFF_GAIN[5:2]] <= GAIN_RST;
      st_ff.cfg[OFF_LIMIT[5:2]] <= LIMIT_RST;
      st_ff.cfg[OFF_BIAS[5:2]] <= BIAS_RST;
      st_ff.mode <= PSS_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = st_ff.rdata;
  assign freq_ref_out = st_ff.freq;
  assign reverse_out = st_ff.reverse;
  assign run_enable_out = st_ff.run_en;
  assign fault_relay_out = st_ff.relay;
  assign feedback_loss_message = st_ff.loss_msg;
  assign source_conflict_alarm = st_ff.conflict;
  assign display_value = st_ff.disp;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sleep_due;
    tick && st_ff.mode == PSS_RUN && sleep_expire && !nxt_st.loss_msg;
  endsequence

  a_disabled_pass: assert property (tick && !loop_en
      |=> freq_ref_out == $past(base_freq_ref) && !reverse_out)
    else $error("disabled loop did not pass the reference");
  a_reverse_gate: assert property ($rose(reverse_out) |-> $past(ctrl[CTRL_REV_ALLOW]))
    else $error("reverse without permission");
  a_integ_limit: assert property ($past(tick) && $past(loop_en) |->
      st_ff.integ <= signed'({2'b00, $past(st_ff.cfg[OFF_LIMIT[5:2]][15:0])})
      && st_ff.integ >= -signed'({2'b00, $past(st_ff.cfg[OFF_LIMIT[5:2]][15:0])}))
    else $error("integrator beyond limit");
  a_freq_full: assert property ($past(tick) && $past(loop_en) && !$past(st_ff.conflict)
      |-> freq_ref_out <= FULL_SCALE)
    else $error("reference above full scale");
  a_loss_time: assert property ($rose(feedback_loss_message)
      |-> $past(st_ff.loss_cnt) >= $past(st_ff.cfg[OFF_LOSS[5:2]][31:16]))
    else $error("loss declared before its time");
  a_warn_runs: assert property (tick && loss_sel == SEL_ONE && st_ff.mode == PSS_RUN
      && !sleep_expire |=> run_enable_out && !fault_relay_out)
    else $error("warning mode stopped the drive");
  a_fault_stop: assert property (tick && loss_sel == SEL_TWO && nxt_st.loss_msg
      |=> fault_relay_out && !run_enable_out && feedback_loss_message)
    else $error("loss fault did not stop the drive");
  a_sleep_enter: assert property (s_sleep_due |=> !run_enable_out ##1 !run_enable_out)
    else $error("sleep not entered on expiry");
  a_wake_delay: assert property (st_ff.mode == PSS_SLEEP && nxt_st.mode == PSS_RUN
      |-> wake_expire || !sleep_allowed)
    else $error("woke before wake delay");
  a_conflict: assert property (tgt_src == fb_src |=> source_conflict_alarm)
    else $error("source conflict not flagged");
  a_timer_clear: assert property (tick && st_ff.mode == PSS_RUN
      && output_freq >= st_ff.cfg[OFF_SLEEP[5:2]][15:0] |=> st_ff.sleep_cnt == 16'h0000)
    else $error("sleep timer not cleared");

endmodule : pss_supervisor

/* verification/pss_drive_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// drive ramp and analog feedback source
// ****************************************************************
module pss_drive_model #(
  parameter logic [15:0] STEP = 16'h0040,
  parameter logic [15:0] TARGET_LEVEL = 16'h0800
) (
  // clock
  input wire logic aclk,
  // from bench and block
  input wire logic [15:0] fb_level,
  input wire logic [15:0] freq_cmd,
  input wire logic run_en,
  // toward block
  output logic [15:0] analog_input_one,
  output logic [15:0] analog_input_two,
  output logic [15:0] output_freq
);
  logic [15:0] goal;
  initial begin
    analog_input_one = TARGET_LEVEL;
    analog_input_two = 16'h0000;
    output_freq = 16'h0000;
  end
  // a stopped drive decelerates to zero; the ramp keeps speed from jumping
  always_comb goal = run_en ? freq_cmd : 16'h0000;
  always @(posedge aclk) begin
    analog_input_two <= fb_level;
    if (goal > output_freq && goal - output_freq > STEP)
      output_freq <= output_freq + STEP;
    else if (output_freq > goal && output_freq - goal > STEP)
      output_freq <= output_freq - STEP;
    else
      output_freq <= goal;
  end
endmodule : pss_drive_model

/* verification/test_pid_supervisor_sleep_wake.sv */
`timescale 1ns/1ns
module test_pid_supervisor_sleep_wake;
  import pss_pkg::*;
  // short tick keeps the timer scenarios brief
  localparam int TK = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, multi_function_digital_input = 2'h0;
  logic [15:0] analog_input_one, analog_input_two, output_freq, freq_ref_out, display_value;
  logic [15:0] base_freq_ref = 16'h0800, fb_level = 16'h0C00;
  logic reverse_out, run_enable_out, fault_relay_out, feedback_loss_message;
  logic source_conflict_alarm;
  int mismatches = 0;
  int samples_checked = 0;
  always #50 aclk = ~aclk;
  pss_supervisor #(.TICK_CYCLES(TK)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .analog_input_one, .analog_input_two,
    .base_freq_ref, .output_freq, .multi_function_digital_input, .freq_ref_out, .reverse_out,
    .run_enable_out, .fault_relay_out, .feedback_loss_message, .source_conflict_alarm,
    .display_value);
  pss_drive_model u_drv (.aclk, .fb_level, .freq_cmd(freq_ref_out), .run_en(run_enable_out),
    .analog_input_one, .analog_input_two, .output_freq);
  // ****************************************************************
  // bus and check helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rdr
  task automatic wrap_up();
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    chk("relay", fault_relay_out, 1'b0);
    wr(8'h40, 32'h0000_0001);
    chk("bresp", rs, RESP_SLVERR);
    rdr(OFF_CTRL);
    chk("ctrl", rd, CTRL_RST);
    rdr(OFF_LIMIT);
    chk("limit", rd, LIMIT_RST);
  endtask : t_regs
  task automatic t_pass();
    cyc(3 * TK);
    chk("ref_off", freq_ref_out, 16'h0800);
    base_freq_ref <= 16'h0A00;
    cyc(2 * TK);
    chk("ref_off2", freq_ref_out, 16'h0A00);
  endtask : t_pass
  task automatic t_conf();
    wr(OFF_CTRL, 32'h0011_0001);
    cyc(2 * TK);
    chk("alarm", source_conflict_alarm, 1'b1);
    chk("ref_conf", freq_ref_out, 16'h0A00);
    wr(OFF_CTRL, CTRL_RST);
    cyc(2);
    chk("alarm_off", source_conflict_alarm, 1'b0);
  endtask : t_conf
  task automatic t_loss();
    fb_level <= 16'h0100;
    wr(OFF_LOSS, 32'h0004_0800);
    wr(OFF_CTRL, 32'h0021_0101);
    cyc(TK);
    chk("msg_early", feedback_loss_message, 1'b0);
    cyc(6 * TK);
    chk("msg_warn", feedback_loss_message, 1'b1);
    chk("run_warn", run_enable_out, 1'b1);
    chk("relay_warn", fault_relay_out, 1'b0);
    fb_level <= 16'h0C00;
    cyc(2 * TK);
    chk("msg_back", feedback_loss_message, 1'b0);
    fb_level <= 16'h0100;
    wr(OFF_CTRL, 32'h0021_0201);
    cyc(6 * TK);
    chk("relay_flt", fault_relay_out, 1'b1);
    chk("run_flt", run_enable_out, 1'b0);
    chk("msg_flt", feedback_loss_message, 1'b1);
    fb_level <= 16'h0C00;
    wr(OFF_CTRL, 32'h0021_0001);
    wr(OFF_STATUS, 32'h0000_0004);
    cyc(2 * TK);
    chk("relay_clr", fault_relay_out, 1'b0);
  endtask : t_loss
  task automatic t_loop();
    cyc(2 * TK);
    chk("ref_fwd", freq_ref_out, 16'h0600);
    wr(OFF_BIAS, 32'h0100_0100);
    cyc(2 * TK);
    chk("ref_bias", freq_ref_out, 16'h0700);
    wr(OFF_BIAS, BIAS_RST);
    wr(OFF_CTRL, 32'h0021_0003);
    cyc(2 * TK);
    chk("ref_inv", freq_ref_out, 16'h0E00);
    base_freq_ref <= 16'h0200;
    wr(OFF_CTRL, 32'h0021_0001);
    cyc(2 * TK);
    chk("ref_neg", freq_ref_out, 16'h0000);
    chk("rev_off", reverse_out, 1'b0);
    wr(OFF_CTRL, 32'h0021_0011);
    cyc(2 * TK);
    chk("ref_rev", freq_ref_out, 16'h0200);
    chk("rev_on", reverse_out, 1'b1);
    base_freq_ref <= 16'h0A00;
    wr(OFF_CTRL, 32'h0021_0001);
    wr(OFF_DISPLAY, 32'h2000_0010);
    cyc(2 * TK);
    chk("disp", display_value, 16'h1810);
    wr(OFF_FILTER, 32'h0040_0000);
    wr(OFF_TARGET, 32'h0000_0C00);
    multi_function_digital_input <= 2'h1;
    wr(OFF_CTRL, 32'h0024_0001);
    cyc(2 * TK);
    chk("ramp_skip", freq_ref_out, 16'h0A00);
    multi_function_digital_input <= 2'h0;
    cyc(TK);
    wr(OFF_TARGET, 32'h0000_0800);
    cyc(2 * TK);
    chk("ramp_mid", freq_ref_out > 16'h0900 && freq_ref_out < 16'h0A00, 1'b1);
    cyc(16 * TK);
    chk("ramp_end", freq_ref_out, 16'h0600);
    wr(OFF_FILTER, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0021_0001);
  endtask : t_loop
  task automatic t_sleep();
    // wake level out of reach, so only the sleep selection can end sleep here
    wr(OFF_WAKE, 32'h0002_FFFF);
    wr(OFF_SLEEP, 32'h0002_FFFF);
    wr(OFF_CTRL, 32'h0021_2001);
    cyc(5 * TK);
    chk("run_di_low", run_enable_out, 1'b1);
    multi_function_digital_input <= 2'h2;
    cyc(5 * TK);
    chk("run_di_high", run_enable_out, 1'b0);
    rdr(OFF_STATUS);
    chk("stat_sleep", rd[STAT_SLEEP], 1'b1);
    multi_function_digital_input <= 2'h0;
    wr(OFF_CTRL, 32'h0021_1001);
    cyc(5 * TK);
    chk("run_sleep", run_enable_out, 1'b0);
    wr(OFF_SLEEP, 32'h0002_0100);
    wr(OFF_WAKE, 32'h0002_0400);
    cyc(5 * TK);
    chk("run_wake", run_enable_out, 1'b1);
    wr(OFF_CTRL, 32'h0021_0001);
    cyc(2 * TK);
    chk("run_nosleep", run_enable_out, 1'b1);
  endtask : t_sleep
  initial begin
    cyc(16);
    aresetn <= 1'b1;
    cyc(3);
    t_regs();
    t_pass();
    t_conf();
    t_loss();
    t_loop();
    t_sleep();
    wrap_up();
  end
  // far above the scenarios' span, so only a hang reaches it
  initial begin
    cyc(20000);
    mismatches++;
    wrap_up();
  end
endmodule : test_pid_supervisor_sleep_wake
